//--- shared/alarm_cfg.svh
// Purpose: offsets, field positions, reset values for the channel and alarm configuration block
// Assumes: 8-bit register port addressed by byte offset
// Notes: included by the core
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH
`define FILTER_CFG_ADDR      8'h11
`define PIN_FUNC_ADDR        8'h12
`define SEL_LOW_ADDR         8'h13
`define SEL_MID_ADDR         8'h14
`define SEL_HIGH_ADDR        8'h15
`define FILTER_CFG_RESET     8'h70
`define PIN_FUNC_RESET       8'h00
`define SEL_RESET            8'h00
`define CH_FILT_MSB          7
`define CH_FILT_LSB          5
`define TEMP_FILT_MSB        4
`define TEMP_FILT_LSB        3
`define ALARM_IN_BIT         0
`define ALARM_OUT_BIT        1
`define TRIG_BIT             2
`define DAV_BIT              3
`define TEMP_SEL_BIT         5
`define NUM_INPUTS           21
`define TEMP_INDEX           21
`endif

//--- shared/alarm_pkg.sv
// Purpose: types for the channel and alarm configuration block
// Assumes: nothing
// Notes: constants live in alarm_cfg.svh
package alarm_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CONV = 3'b010,
    SEQ_NEXT = 3'b100
  } seq_state_t;
endpackage

//--- core/violation_counter_mem.sv
// Purpose: per-channel consecutive violation counters
// Assumes: one read and one write per cycle
// Notes: read data registered
`timescale 1ns/10ps
`default_nettype none
module violation_counter_mem #(
  parameter int DEPTH = 22,
  parameter int WIDTH = 9,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // read side
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out,
  // write side
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) rdata_out <= '0;
    else rdata_out <= mem_q[raddr_in];
  end
endmodule
`default_nettype wire

//--- core/alarm_config_core.sv
// Purpose: input selection, sequencing, alarm filtering and shared pin steering
// Assumes: inputs synchronous to clk_in; register port is a simple strobed byte port
// Notes: Notes on behaviour listed below
// Notes on behaviour
// [RL1] an input alarm is raised only after N bad samples in a row, N = 1,4,8,...,256 by a 3-bit code.
// [RL2] a thermal alarm is raised only after N bad samples in a row, N = 1,2,4,8 by a 2-bit code.
// [RL3] pin function bit 1 turns shared pin 1 from general I/O into the alarm output.
// [RL4] pin function bit 0 turns shared pin 0 from general I/O into the alarm input.
// [RL5] pin function bit 2 turns shared pin 2 from general I/O into the conversion trigger input.
// [RL6] pin function bit 3 turns shared pin 3 from general I/O into the data valid output.
// [RL7] input n joins a conversion cycle when its select bit at 0x13, 0x14 or 0x15 is set.
// [RL8] inputs with a clear select bit are skipped, and all select bits reset to zero.
// [RL9] bit 5 at 0x15 puts the thermal sensor into the sequence.
// [RL10] the host keeps the reserved bits of the pin function and high select registers at zero.
// [RL11] the input filter field is bits 7-5 resetting to 011, the thermal field bits 4-3 resetting to 10.
// [RL12] direct mode runs the sequence once per trigger, auto mode repeats it from the first channel.
// [RL13] each channel has its own run counter, cleared by an in-range sample, alarming at N.
// [RL14] enabled channels go in ascending order, thermal last, and disabled ones take no slot.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_cfg.svh"
module alarm_config_core
  import alarm_pkg::*;
#(
  parameter int NCH = 22
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  // conversion control
  input  wire logic        conversion_sequence_style_in,
  input  wire logic        soft_trigger_in,
  output logic      [4:0]  conv_channel_out,
  output logic             conv_start_out,
  input  wire logic        conv_done_in,
  input  wire logic        conv_out_of_range_in,
  output logic             seq_busy_out,
  // alarm state
  output logic      [NCH-1:0] channel_alarm_out,
  // shared pins, general I/O side
  input  wire logic [3:0]  gpio_out_in,
  input  wire logic [3:0]  gpio_oe_in,
  output logic      [3:0]  gpio_in_out,
  // shared pins, pad side
  input  wire logic [3:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe_out,
  // alternate functions
  input  wire logic        alarm_source_in,
  input  wire logic        data_valid_indication_in,
  output logic             alarm_input_pin_out
);
  logic [7:0] filter_cfg_q;
  logic [7:0] pin_func_q;
  logic [7:0] sel_low_q;
  logic [7:0] sel_mid_q;
  logic [7:0] sel_high_q;
  logic [NCH-1:0] enable_mask;
  seq_state_t state_q;
  logic [4:0] chan_q;
  logic       repeat_q;
  logic [8:0] run_count;
  logic [8:0] run_next;
  logic [8:0] run_limit;
  logic       trig_fire;
  logic       trig_q;

  // register writes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      filter_cfg_q <= `FILTER_CFG_RESET; // RL11
      pin_func_q   <= `PIN_FUNC_RESET;
      sel_low_q    <= `SEL_RESET; // RL8
      sel_mid_q    <= `SEL_RESET;
      sel_high_q   <= `SEL_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `FILTER_CFG_ADDR: filter_cfg_q <= reg_wdata_in;
        `PIN_FUNC_ADDR:   pin_func_q   <= reg_wdata_in;
        `SEL_LOW_ADDR:    sel_low_q    <= reg_wdata_in;
        `SEL_MID_ADDR:    sel_mid_q    <= reg_wdata_in;
        `SEL_HIGH_ADDR:   sel_high_q   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // register reads, registered
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FILTER_CFG_ADDR: reg_rdata_out <= filter_cfg_q;
        `PIN_FUNC_ADDR:   reg_rdata_out <= pin_func_q;
        `SEL_LOW_ADDR:    reg_rdata_out <= sel_low_q;
        `SEL_MID_ADDR:    reg_rdata_out <= sel_mid_q;
        `SEL_HIGH_ADDR:   reg_rdata_out <= sel_high_q;
        default:          reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // channel enables, thermal on top
  assign enable_mask = {sel_high_q[`TEMP_SEL_BIT], sel_high_q[4:0],
                        sel_mid_q, sel_low_q}; // RL7 RL9

  // lowest enabled channel at or above cur, or NCH if none
  function automatic logic [4:0] next_enabled(input logic [NCH-1:0] m, input logic [5:0] cur);
    logic [4:0] r;
    r = 5'(NCH);
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i] && (6'(i) >= cur)) r = 5'(i);
    end
    return r;
  endfunction

  // input N by code
  function automatic logic [8:0] ch_limit(input logic [2:0] c);
    return (c == 3'b000) ? 9'h001 : 9'(9'h002 << c); // RL1
  endfunction

  // thermal N by code
  function automatic logic [8:0] temp_limit(input logic [1:0] c);
    return 9'(9'h001 << c); // RL2
  endfunction

  // trigger: soft or shared pin 2 when steered
  assign trig_fire = soft_trigger_in |
                     (pin_func_q[`TRIG_BIT] & pin_in[2] & ~trig_q); // RL5

  // tracks the pad through reset as well, so a pin held high gives no false edge
  always_ff @(posedge clk_in) begin
    trig_q <= pin_in[2];
  end

  // sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q  <= SEQ_IDLE;
      chan_q   <= 5'h00;
      repeat_q <= 1'b0;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (trig_fire || repeat_q) begin
            chan_q <= next_enabled(enable_mask, 6'h00); // RL14
            state_q <= (next_enabled(enable_mask, 6'h00) == 5'(NCH)) ? SEQ_IDLE : SEQ_CONV;
            repeat_q <= 1'b0;
          end
        end
        SEQ_CONV: begin
          if (conv_done_in) state_q <= SEQ_NEXT;
        end
        SEQ_NEXT: begin
          if (next_enabled(enable_mask, 6'(chan_q) + 6'h01) == 5'(NCH)) begin // RL8
            state_q  <= SEQ_IDLE;
            repeat_q <= conversion_sequence_style_in; // RL12
          end else begin
            chan_q  <= next_enabled(enable_mask, 6'(chan_q) + 6'h01); // RL14
            state_q <= SEQ_CONV;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  assign conv_channel_out = chan_q;
  assign seq_busy_out = (state_q != SEQ_IDLE);

  // one start pulse per slot
  always_ff @(posedge clk_in) begin
    if (srst_in) conv_start_out <= 1'b0;
    else conv_start_out <= (state_q != SEQ_CONV) &&
      ((state_q == SEQ_IDLE && (trig_fire || repeat_q) &&
        next_enabled(enable_mask, 6'h00) != 5'(NCH)) ||
       (state_q == SEQ_NEXT && next_enabled(enable_mask, 6'(chan_q) + 6'h01) != 5'(NCH)));
  end

  // run counters
  violation_counter_mem #(.DEPTH(NCH), .WIDTH(9), .AW(5)) counters (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .raddr_in  (chan_q),
    .rdata_out (run_count),
    .we_in     (state_q == SEQ_CONV && conv_done_in),
    .waddr_in  (chan_q),
    .wdata_in  (run_next)
  );

  assign run_limit = (chan_q == 5'(`TEMP_INDEX)) ?
    temp_limit(filter_cfg_q[`TEMP_FILT_MSB:`TEMP_FILT_LSB]) :
    ch_limit(filter_cfg_q[`CH_FILT_MSB:`CH_FILT_LSB]);
  assign run_next = !conv_out_of_range_in ? 9'h000 :
                    (run_count >= run_limit) ? run_limit : run_count + 9'h001; // RL13

  // alarm flags follow the counters
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      channel_alarm_out <= '0;
    end else if (state_q == SEQ_CONV && conv_done_in) begin
      channel_alarm_out[chan_q] <= conv_out_of_range_in && (run_next >= run_limit); // RL1 RL2 RL13
    end
  end

  // shared pin steering
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_out    <= 4'h0;
      pin_oe_out <= 4'h0;
    end else begin
      pin_out[0]    <= gpio_out_in[0];
      pin_oe_out[0] <= pin_func_q[`ALARM_IN_BIT] ? 1'b0 : gpio_oe_in[0]; // RL4
      pin_out[1]    <= pin_func_q[`ALARM_OUT_BIT] ? alarm_source_in : gpio_out_in[1]; // RL3
      pin_oe_out[1] <= pin_func_q[`ALARM_OUT_BIT] ? 1'b1 : gpio_oe_in[1];
      pin_out[2]    <= gpio_out_in[2];
      pin_oe_out[2] <= pin_func_q[`TRIG_BIT] ? 1'b0 : gpio_oe_in[2]; // RL5
      pin_out[3]    <= pin_func_q[`DAV_BIT] ? data_valid_indication_in : gpio_out_in[3]; // RL6
      pin_oe_out[3] <= pin_func_q[`DAV_BIT] ? 1'b1 : gpio_oe_in[3];
    end
  end

  assign gpio_in_out = pin_in;
  assign alarm_input_pin_out = pin_func_q[`ALARM_IN_BIT] & pin_in[0]; // RL4
endmodule
`default_nettype wire

//--- verification/alarm_config_monitor.sv
// Purpose: port checker for the alarm configuration core
// Assumes: one clock, sync reset
// Notes: bound into each core instance
`timescale 1ns/10ps
`default_nettype none
module alarm_config_monitor #(parameter int NCH = 22) (
  // watched ports
  input wire logic           clk_in,
  input wire logic           srst_in,
  input wire logic           conv_done_in,
  input wire logic           conv_out_of_range_in,
  input wire logic           conv_start_out,
  input wire logic [4:0]     conv_channel_out,
  input wire logic           seq_busy_out,
  input wire logic [NCH-1:0] channel_alarm_out,
  input wire logic [3:0]     pin_in,
  input wire logic           alarm_input_pin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_sample; conv_done_in && seq_busy_out; endsequence
  sequence s_go_on; conv_start_out || !seq_busy_out; endsequence
  AST_NEXT_SLOT: assert property (s_sample |-> ##[1:4] s_go_on)
    else $error("stall");
  AST_START_ONE: assert property (conv_start_out |=> !conv_start_out)
    else $error("long start");
  AST_BUSY_START: assert property ($rose(seq_busy_out) |-> ##[0:1] conv_start_out)
    else $error("no start");
  AST_START_BUSY: assert property (conv_start_out |-> seq_busy_out)
    else $error("idle start");
  AST_CHAN: assert property (conv_start_out |-> conv_channel_out <= 5'h15)
    else $error("bad channel");
  AST_ALM_SET: assert property ((channel_alarm_out & ~$past(channel_alarm_out)) != '0
    |-> $past(conv_done_in && conv_out_of_range_in)) else $error("alarm set");
  AST_ALM_CLR: assert property ((~channel_alarm_out & $past(channel_alarm_out)) != '0
    |-> $past(srst_in) || $past(conv_done_in && !conv_out_of_range_in))
    else $error("alarm clear");
  AST_ALM_IN: assert property (alarm_input_pin_out |-> pin_in[0])
    else $error("alarm in");
endmodule
bind alarm_config_core alarm_config_monitor #(.NCH(NCH)) u_mon (.clk_in(clk_in),
  .srst_in(srst_in), .conv_done_in(conv_done_in), .conv_out_of_range_in(conv_out_of_range_in),
  .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
  .seq_busy_out(seq_busy_out), .channel_alarm_out(channel_alarm_out), .pin_in(pin_in),
  .alarm_input_pin_out(alarm_input_pin_out));
`default_nettype wire

//--- verification/adc_far_end.sv
// Purpose: far-end converter answering each slot
// Assumes: one slot at a time
// Notes: range flag inverted outside done
`timescale 1ns/10ps
`default_nettype none
module adc_far_end (
  // slot request and answer
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,
  input  wire logic [4:0]  chan_in,
  input  wire logic [21:0] bad_mask_in,
  output logic             done_out,
  output logic             oor_out
);
  logic [1:0] wait_q;
  always_ff @(posedge clk_in) begin
    wait_q   <= srst_in ? 2'h0 : {wait_q[0], start_in};
    done_out <= !srst_in && wait_q[1];
  end
  assign oor_out = done_out ? bad_mask_in[chan_in] : !bad_mask_in[chan_in];
endmodule
`default_nettype wire

//--- verification/adc_channel_and_alarm_config_bench.sv
// Purpose: self-checking bench for the alarm configuration core
// Assumes: far-end model answers every slot
// Notes: drives on rising edges, samples on falling edges
`timescale 1ns/10ps
`default_nettype none
module adc_channel_and_alarm_config_bench;
  logic        clk_in = 1'b0, srst_in = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sty = 1'b0, trg = 1'b0;
  logic        cs, dn, oor, busy, ain;
  logic [7:0]  adr = '0, wd = '0, rdat;
  logic [4:0]  ch, seen[$];
  logic [4:0]  ord[4] = '{5'h00, 5'h09, 5'h14, 5'h15};
  logic [21:0] alm, bad = '0;
  logic [3:0]  pin = '0, pout, poe, gin;
  int          fail_count = 0, n_checks = 0;
  alarm_config_core i_dut (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(adr),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .conversion_sequence_style_in(sty), .soft_trigger_in(trg), .conv_channel_out(ch),
    .conv_start_out(cs), .conv_done_in(dn), .conv_out_of_range_in(oor),
    .seq_busy_out(busy), .channel_alarm_out(alm), .gpio_out_in(4'h0), .gpio_oe_in(4'hf),
    .gpio_in_out(gin), .pin_in(pin), .pin_out(pout), .pin_oe_out(poe),
    .alarm_source_in(1'b1), .data_valid_indication_in(1'b1), .alarm_input_pin_out(ain));
  adc_far_end u_far (.clk_in(clk_in), .srst_in(srst_in), .start_in(cs), .chan_in(ch),
    .bad_mask_in(bad), .done_out(dn), .oor_out(oor));
  initial forever #25 clk_in = ~clk_in;
  always @(negedge clk_in) if (cs === 1'b1) seen.push_back(ch);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) fail_count++;
    if (g !== e) $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    {adr, wd} <= {a, d};
    wr_s <= 1'b1;
    @(posedge clk_in) wr_s <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in) rd_s <= 1'b0;
    @(negedge clk_in) chk(rdat, e);
    @(posedge clk_in);
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 2 || (busy !== 1'b0 && k < 400); k++) @(negedge clk_in);
    chk(k < 400, 1'b1);
    if (k >= 400) wrap_up();
    @(posedge clk_in);
  endtask
  task automatic t_filt;
    logic [21:0] exp_alm[5] = '{22'h200000, 22'h200000, 22'h200000, 22'h300201, 22'h0};
    reg_rd(8'h11, 8'h70);
    reg_rd(8'h15, 8'h00);
    reg_wr(8'h20, 8'hff);
    reg_rd(8'h20, 8'h00);
    reg_wr(8'h11, 8'h20);
    reg_wr(8'h13, 8'h01);
    reg_wr(8'h14, 8'h02);
    reg_wr(8'h15, 8'h30);
    reg_rd(8'h15, 8'h30);
    for (int r = 0; r < 5; r++) begin
      bad <= (r < 4) ? '1 : '0;
      seen.delete();
      trg <= 1'b1;
      @(posedge clk_in) trg <= 1'b0;
      wait_idle();
      foreach (ord[i]) chk(seen[i], ord[i]);
      chk(seen.size(), 4);
      chk(alm, exp_alm[r]);
    end
    $display("filter test done");
  endtask
  task automatic t_pins;
    reg_wr(8'h12, 8'h0f);
    pin <= 4'h1;
    @(negedge clk_in) chk({pout[3], pout[1], poe[2], poe[0], ain}, 5'h19);
    @(posedge clk_in);
    seen.delete();
    pin <= 4'h5;
    wait_idle();
    chk(seen.size(), 4);
    reg_wr(8'h12, 8'h00);
    @(negedge clk_in) chk({pout[3], pout[1], poe, ain, gin}, 11'h1e5);
    @(posedge clk_in);
    seen.delete();
    pin <= 4'h0;
    @(posedge clk_in) pin <= 4'h4;
    repeat (3) @(posedge clk_in);
    chk(seen.size(), 0);
    $display("pin test done");
  endtask
  task automatic t_auto;
    seen.delete();
    sty <= 1'b1;
    trg <= 1'b1;
    @(posedge clk_in) trg <= 1'b0;
    repeat (60) @(posedge clk_in);
    sty <= 1'b0;
    wait_idle();
    chk(seen.size() > 5, 1'b1);
    foreach (seen[i]) chk(seen[i], ord[i % 4]);
    $display("auto test done");
  endtask
  task automatic t_codes;
    reg_wr(8'h11, 8'h18);
    for (int r = 0; r < 8; r++) begin
      bad <= '1;
      trg <= 1'b1;
      @(posedge clk_in) trg <= 1'b0;
      wait_idle();
      chk(alm, (r < 7) ? 32'h100201 : 32'h300201);
    end
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in) chk({alm, busy, cs}, 24'h0);
    @(posedge clk_in);
    reg_rd(8'h11, 8'h70);
    reg_rd(8'h13, 8'h00);
    $display("code and reset test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_filt();
    t_pins();
    t_auto();
    t_codes();
    wrap_up();
  end
endmodule
`default_nettype wire
